/* hw/xirq_pkg.sv */
// xirq_pkg: constants and carriers for the extended interrupt mask/priority
// and power-mode block; shared by the block and its registered split helper.
package xirq_pkg;
   // special-function addresses
   localparam logic [7:0] ADDR_EXT_IRQ_ENABLE_2   = 8'hE7;
   localparam logic [7:0] ADDR_EXT_IRQ_PRIORITY_1 = 8'hF6;
   localparam logic [7:0] ADDR_EXT_IRQ_PRIORITY_2 = 8'hF7;
   localparam logic [7:0] ADDR_POWER_CONTROL      = 8'h87;
   // reset values
   localparam logic [7:0] RST_EXT_IRQ_ENABLE_2    = 8'h00;
   localparam logic [7:0] RST_EXT_IRQ_PRIORITY_1  = 8'h00;
   localparam logic [7:0] RST_EXT_IRQ_PRIORITY_2  = 8'h00;
   localparam logic [7:0] RST_POWER_CONTROL       = 8'h00;
   // power control fields
   localparam int         BIT_IDLE_SEL            = 0;
   localparam int         BIT_STOP_SEL            = 1;
   localparam logic [7:0] POWER_CONTROL_MODE_MASK          = 8'h03;
   // enable register 2 field positions
   localparam int BIT_TIMER_THREE  = 0;
   localparam int BIT_ADC_A_EOC    = 1;
   localparam int BIT_TIMER_FOUR   = 2;
   localparam int BIT_ADC_B_EOC    = 3;
   localparam int BIT_EXT_IRQ_SIX  = 4;
   localparam int BIT_EXT_IRQ_SEVEN = 5;
   localparam int BIT_UART_B       = 6;
   localparam int BIT_CRYSTAL_VALID = 7;
   // overflow / valid flag position in the owning control registers
   localparam int BIT_CTRL_FLAG    = 7;
   // missing-clock detector timeout
   localparam int CLK_HZ           = 20_000_000;
   localparam int MCD_TIMEOUT_US   = 100;
   localparam int MCD_TIMEOUT_CYC  = (CLK_HZ / 1_000_000) * MCD_TIMEOUT_US;

   typedef enum logic [2:0] {
      PWR_RUN  = 3'b001,
      PWR_IDLE = 3'b010,
      PWR_STOP = 3'b100
   } pwr_state_t;

   // special-function bus write/read request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_t;

   // one-per-bit request sources of the second extended group
   typedef struct packed {
      logic [7:0] timer_four_control;
      logic [7:0] timer_three_control;
      logic [7:0] ext_osc_control;
      logic       uart_b;
      logic       ext_irq_seven;
      logic       ext_irq_six;
      logic       adc_b_eoc;
      logic       adc_a_eoc;
   } irq_src_t;
endpackage

/* hw/xirq_power_ctrl.sv */
// xirq_power_ctrl: extended enable 2 and priority 1/2 registers, the power
// control mode bits, and the idle/stop state of the core.
// assumes a single-cycle special-function bus from the core; the core
// honours halt_o and restarts at 0x0000 on any reset it receives.
// the watchdog and missing-clock detector live outside; their resets
// arrive on rst_i, so this block never times anything itself.
//
// Operation
// - enable two resets zero, one enables
// - timer four request from overflow flag
// - timer three request from overflow flag
// - crystal request from oscillator valid flag
// - priority one resets zero, one high (here only held and read back; priority two drives the split)
// - priority two resets zero, one high
// - idle halts core, peripherals keep running
// - enabled interrupt leaves idle, resumes core
// - reset ends idle, restart at zero
// - enabled watchdog reset ends idle
// - stop halts core and system clock
// - only reset leaves stop, no interrupts
// - missing clock detector reset ends stop
// - power control at 0x87, reads zero
// - requests sampled and decoded every cycle
`timescale 1ns/10ps
module xirq_power_ctrl (
   // clock and reset (system reset covers pin, watchdog and detector)
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // special-function bus
   input  wire xirq_pkg::sfr_req_t sfr_i,
   output logic            [7:0]  rdata_o,
   output logic                   rhit_o,
   // interrupt sources and base-group wake
   input  wire xirq_pkg::irq_src_t src_i,
   input  wire logic              other_irq_i,
   input  wire logic              global_en_i,
   // decoded requests to the core
   output logic            [7:0]  irq_high_o,
   output logic            [7:0]  irq_low_o,
   // power state
   output logic                   halt_o,
   output logic                   clk_stop_o,
   output logic                   idle_o
);
   import xirq_pkg::*;

   logic       [7:0] enable_q;
   logic       [7:0] prio1_q;
   logic       [7:0] prio2_q;
   logic       [7:0] raw_req;
   logic       [7:0] masked_req;
   logic       [7:0] rdata_d;
   logic             rhit_d;
   logic             wake;
   logic             wr_enable;
   logic             wr_prio1;
   logic             wr_prio2;
   logic             wr_power;
   pwr_state_t       state_q;

   // write strobes; the core makes at most one access per cycle
   assign wr_enable = sfr_i.wr && (sfr_i.addr == ADDR_EXT_IRQ_ENABLE_2);
   assign wr_prio1  = sfr_i.wr && (sfr_i.addr == ADDR_EXT_IRQ_PRIORITY_1);
   assign wr_prio2  = sfr_i.wr && (sfr_i.addr == ADDR_EXT_IRQ_PRIORITY_2);
   assign wr_power  = sfr_i.wr && (sfr_i.addr == ADDR_POWER_CONTROL);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         enable_q <= RST_EXT_IRQ_ENABLE_2;
      end else if (wr_enable) begin
         enable_q <= sfr_i.wdata;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prio1_q <= RST_EXT_IRQ_PRIORITY_1;
      end else if (wr_prio1) begin
         prio1_q <= sfr_i.wdata;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prio2_q <= RST_EXT_IRQ_PRIORITY_2;
      end else if (wr_prio2) begin
         prio2_q <= sfr_i.wdata;
      end
   end

   // source mapping; flags live in their owners' control registers
   // low control bits may change freely; only the flag bit raises a request
   always_comb begin
      raw_req = 8'h00;
      raw_req[BIT_TIMER_THREE]   = src_i.timer_three_control[BIT_CTRL_FLAG];
      raw_req[BIT_ADC_A_EOC]     = src_i.adc_a_eoc;
      raw_req[BIT_TIMER_FOUR]    = src_i.timer_four_control[BIT_CTRL_FLAG];
      raw_req[BIT_ADC_B_EOC]     = src_i.adc_b_eoc;
      raw_req[BIT_EXT_IRQ_SIX]   = src_i.ext_irq_six;
      raw_req[BIT_EXT_IRQ_SEVEN] = src_i.ext_irq_seven;
      raw_req[BIT_UART_B]        = src_i.uart_b;
      raw_req[BIT_CRYSTAL_VALID] = src_i.ext_osc_control[BIT_CTRL_FLAG];
   end

   // per-bit masking, gated by global enable
   assign masked_req = global_en_i ? (raw_req & enable_q) : 8'h00;

   // priority one is only held for the core; its sources live elsewhere
   // priority decode
   xirq_prio_split u_split (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .req_i  (masked_req),
      .prio_i (prio2_q),
      .high_o (irq_high_o),
      .low_o  (irq_low_o)
   );

   // wake uses the same masking as the core, so a disabled source
   // cannot end idle on its own
   assign wake = (|masked_req) || other_irq_i;

   // stop is final: only rst_i can take the machine out of it
   // power state; any system reset (pin, watchdog, detector) lands in run
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= PWR_RUN;
      end else begin
         unique case (state_q)
            PWR_RUN: begin
               if (wr_power && sfr_i.wdata[BIT_STOP_SEL]) begin
                  state_q <= PWR_STOP;
               end else if (wr_power && sfr_i.wdata[BIT_IDLE_SEL]) begin
                  state_q <= PWR_IDLE;
               end
            end
            PWR_IDLE: begin
               if (wake) begin
                  state_q <= PWR_RUN;
               end
            end
            PWR_STOP: begin
               // only reset leaves
               // interrupts are ignored; in silicon the clock is already gone
               state_q <= PWR_STOP;
            end
            // a corrupted one-hot code falls back to run rather than hang
            default: state_q <= PWR_RUN;
         endcase
      end
   end

   // halt follows the state one edge later; a wake in idle drops it at once
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         halt_o <= 1'b0;
      end else begin
         halt_o <= (state_q != PWR_RUN) && !(state_q == PWR_IDLE && wake);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clk_stop_o <= 1'b0;
      end else begin
         clk_stop_o <= (state_q == PWR_STOP);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         idle_o <= 1'b0;
      end else begin
         idle_o <= (state_q == PWR_IDLE) && !wake;
      end
   end

   // reads have no side effects, so decoding every cycle is harmless
   always_comb begin
      rdata_d = 8'h00;
      rhit_d  = 1'b1;
      unique case (sfr_i.addr)
         ADDR_EXT_IRQ_ENABLE_2:   rdata_d = enable_q;
         ADDR_EXT_IRQ_PRIORITY_1: rdata_d = prio1_q;
         ADDR_EXT_IRQ_PRIORITY_2: rdata_d = prio2_q;
         ADDR_POWER_CONTROL:      rdata_d = RST_POWER_CONTROL & ~POWER_CONTROL_MODE_MASK;
         default:                 rhit_d  = 1'b0;
      endcase
   end

   // read data registered; other power-control bits belong elsewhere
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_o <= 8'h00;
      end else begin
         rdata_o <= sfr_i.rd ? rdata_d : 8'h00;
      end
   end

   // hit flag tells the core that this block answered the read
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rhit_o <= 1'b0;
      end else begin
         rhit_o <= sfr_i.rd && rhit_d;
      end
   end
endmodule

/* hw/xirq_prio_split.sv */
// xirq_prio_split: registered split of masked requests into high and low
// priority groups.
// assumes requests and masks are synchronous to clk_i.
`timescale 1ns/10ps
module xirq_prio_split (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // requests and priority
   input  wire logic [7:0] req_i,
   input  wire logic [7:0] prio_i,
   // decoded groups
   output logic      [7:0] high_o,
   output logic      [7:0] low_o
);
   import xirq_pkg::*;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         high_o <= 8'h00;
         low_o  <= 8'h00;
      end else begin
         high_o <= req_i & prio_i;
         low_o  <= req_i & ~prio_i;
      end
   end
endmodule

/* test/tb.sv */
// self-checking bench for xirq_power_ctrl
// assumes the package constants and a 50 ns clock
`timescale 1ns/10ps
module tb;
   import xirq_pkg::*;
   logic clk_i, rst_i, other_irq_i, global_en_i, rhit_o, halt_o, clk_stop_o, idle_o;
   sfr_req_t sfr_i;
   irq_src_t src_i;
   logic [7:0] rdata_o, irq_high_o, irq_low_o, req, en, pr;
   logic [6:0] fill;
   logic [31:0] seed;
   int n_errors, cmp_count;
   xirq_periph_model pm (.req_i(req), .fill_i(fill), .src_o(src_i));
   xirq_power_ctrl uut (.clk_i, .rst_i, .sfr_i, .rdata_o, .rhit_o, .src_i, .other_irq_i,
      .global_en_i, .irq_high_o, .irq_low_o, .halt_o, .clk_stop_o, .idle_o);
   initial begin
      clk_i = 0;
      forever #25 clk_i = ~clk_i;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [7:0] exp_irq(bit hi);
      return req & en & (hi ? pr : ~pr) & {8{global_en_i}};
   endfunction
   task chk(string nm, logic [7:0] s, logic [7:0] e);
      cmp_count++;
      if (s !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task sfr(logic w, logic [7:0] a, logic [7:0] d);
      @(posedge clk_i);
      sfr_i <= '{w, !w, a, d};
      @(posedge clk_i);
      sfr_i <= '0;
   endtask
   task rd(logic [7:0] a, logic h, logic [7:0] e);
      sfr(0, a, 8'h00);
      #1;
      chk("rhit", {7'h00, rhit_o}, {7'h00, h});
      chk("rdata", rdata_o, e);
   endtask
   task pwr(string nm, logic [2:0] e);
      #1;
      chk(nm, {5'h00, halt_o, clk_stop_o, idle_o}, {5'h00, e});
   endtask
   task finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clk_i) fill <= 7'(rnd());
   initial begin
      repeat (20000) @(posedge clk_i);
      n_errors++;
      finish_test();
   end
   initial begin
      seed = 32'h0000_AE72;
      {rst_i, sfr_i, req, other_irq_i, global_en_i, en, pr} = '0;
      rst_i = 1;
      repeat (20) @(posedge clk_i);
      rst_i <= 0;
      rd(ADDR_EXT_IRQ_ENABLE_2, 1, RST_EXT_IRQ_ENABLE_2);
      rd(ADDR_EXT_IRQ_PRIORITY_1, 1, RST_EXT_IRQ_PRIORITY_1);
      rd(ADDR_EXT_IRQ_PRIORITY_2, 1, RST_EXT_IRQ_PRIORITY_2);
      rd(8'h55, 0, 8'h00);
      sfr(1, ADDR_POWER_CONTROL, 8'hFC);
      rd(ADDR_POWER_CONTROL, 1, 8'h00);
      $display("register reset test done");
      for (int i = 0; i < 12; i++) begin
         en = (i == 0) ? 8'hFF : 8'(rnd());
         pr = (i == 0) ? 8'h0C : 8'(rnd());
         sfr(1, ADDR_EXT_IRQ_ENABLE_2, en);
         sfr(1, ADDR_EXT_IRQ_PRIORITY_2, pr);
         sfr(1, ADDR_EXT_IRQ_PRIORITY_1, ~pr);
         rd(ADDR_EXT_IRQ_ENABLE_2, 1, en);
         rd(ADDR_EXT_IRQ_PRIORITY_1, 1, ~pr);
         rd(ADDR_EXT_IRQ_PRIORITY_2, 1, pr);
         @(posedge clk_i);
         req <= (i == 0) ? 8'hFF : 8'(rnd());
         global_en_i <= (i % 4 != 3);
         @(posedge clk_i);
         #1;
         chk("irq_high", irq_high_o, exp_irq(1));
         chk("irq_low", irq_low_o, exp_irq(0));
      end
      $display("mask and priority test done");
      @(posedge clk_i);
      global_en_i <= 0;
      sfr(1, ADDR_POWER_CONTROL, 8'h01);
      repeat (3) @(posedge clk_i);
      pwr("idle", 3'b101);
      @(posedge clk_i);
      other_irq_i <= 1;
      @(posedge clk_i);
      other_irq_i <= 0;
      repeat (2) @(posedge clk_i);
      pwr("wake", 3'b000);
      sfr(1, ADDR_EXT_IRQ_ENABLE_2, 8'h01);
      @(posedge clk_i);
      {global_en_i, req} <= {1'b1, 8'hFE};
      sfr(1, ADDR_POWER_CONTROL, 8'h01);
      repeat (3) @(posedge clk_i);
      pwr("idle_masked", 3'b101);
      @(posedge clk_i);
      req <= 8'hFF;
      repeat (2) @(posedge clk_i);
      pwr("wake_req", 3'b000);
      @(posedge clk_i);
      {global_en_i, req} <= 9'h000;
      sfr(1, ADDR_POWER_CONTROL, 8'h01);
      repeat (3) @(posedge clk_i);
      pwr("idle_again", 3'b101);
      @(posedge clk_i);
      rst_i <= 1;
      repeat (2) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      pwr("idle_reset", 3'b000);
      rd(ADDR_EXT_IRQ_ENABLE_2, 1, RST_EXT_IRQ_ENABLE_2);
      sfr(1, ADDR_POWER_CONTROL, 8'h03);
      @(posedge clk_i);
      {other_irq_i, global_en_i, req} <= {2'b11, 8'hFF};
      repeat (5) @(posedge clk_i);
      pwr("stop", 3'b110);
      @(posedge clk_i);
      rst_i <= 1;
      repeat (2) @(posedge clk_i);
      {rst_i, other_irq_i} <= 2'b00;
      @(posedge clk_i);
      pwr("stop_reset", 3'b000);
      $display("power mode test done");
      finish_test();
   end
endmodule

/* test/xirq_periph_model.sv */
// peripheral flag sources facing the block
// assumes the bench sets request levels and filler bits each cycle
`timescale 1ns/10ps
module xirq_periph_model (
   // request levels, bit order of the enable register
   input  wire logic [7:0]  req_i,
   input  wire logic [6:0]  fill_i,
   // packed sources
   output xirq_pkg::irq_src_t src_o
);
   import xirq_pkg::*;
   // flags at bit seven
   // low bits churn so only the flag bit may count
   assign src_o.timer_four_control = {req_i[BIT_TIMER_FOUR], fill_i};
   assign src_o.timer_three_control = {req_i[BIT_TIMER_THREE], ~fill_i};
   assign src_o.ext_osc_control = {req_i[BIT_CRYSTAL_VALID], fill_i};
   assign src_o.uart_b = req_i[BIT_UART_B];
   assign src_o.ext_irq_seven = req_i[BIT_EXT_IRQ_SEVEN];
   assign src_o.ext_irq_six = req_i[BIT_EXT_IRQ_SIX];
   assign src_o.adc_b_eoc = req_i[BIT_ADC_B_EOC];
   assign src_o.adc_a_eoc = req_i[BIT_ADC_A_EOC];
endmodule

/* test/xirq_power_ctrl_asserts.sv */
// checks at the ports of the extended mask/priority and power block
// assumes one clock domain and a bind onto xirq_power_ctrl
`timescale 1ns/10ps
module xirq_power_ctrl_asserts (
   // observed ports
   input wire logic               clk_i,
   input wire logic               rst_i,
   input wire xirq_pkg::sfr_req_t sfr_i,
   input wire logic [7:0]         rdata_o,
   input wire logic               rhit_o,
   input wire logic               other_irq_i,
   input wire logic               global_en_i,
   input wire logic [7:0]         irq_high_o,
   input wire logic [7:0]         irq_low_o,
   input wire logic               halt_o,
   input wire logic               clk_stop_o,
   input wire logic               idle_o
);
   import xirq_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic pw, hit, calm;
   assign pw = sfr_i.wr && sfr_i.addr == ADDR_POWER_CONTROL && !halt_o;
   assign hit = sfr_i.addr inside {ADDR_EXT_IRQ_ENABLE_2, ADDR_EXT_IRQ_PRIORITY_1,
                                   ADDR_EXT_IRQ_PRIORITY_2, ADDR_POWER_CONTROL};
   assign calm = !other_irq_i && !global_en_i;
   property p_rd_hit; sfr_i.rd && hit |=> rhit_o; endproperty
   a_rd_hit: assert property (p_rd_hit) else $error("mapped read gave no hit");
   property p_unmapped; sfr_i.rd && !hit |=> !rhit_o && rdata_o == 8'h00; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
   property p_power_control_zero;
      sfr_i.rd && sfr_i.addr == ADDR_POWER_CONTROL |=> rdata_o == 8'h00;
   endproperty
   a_power_control_zero: assert property (p_power_control_zero) else $error("mode bits read back");
   property p_idle_in; pw && sfr_i.wdata[1:0] == 2'b01 && calm ##1 calm ##1 calm
      |=> idle_o && halt_o && !clk_stop_o; endproperty
   a_idle_in: assert property (p_idle_in) else $error("idle not entered");
   property p_idle_hold; idle_o && calm ##1 calm |-> idle_o; endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("idle left unasked");
   property p_wake; idle_o && !other_irq_i ##1 other_irq_i |=> !idle_o && !halt_o; endproperty
   a_wake: assert property (p_wake) else $error("interrupt did not end idle");
   property p_stop_in; pw && sfr_i.wdata[1] |-> ##3 clk_stop_o && halt_o; endproperty
   a_stop_in: assert property (p_stop_in) else $error("stop not entered");
   property p_stop_hold; clk_stop_o |=> clk_stop_o && halt_o && !idle_o; endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("stop left without reset");
   property p_split; (irq_high_o & irq_low_o) == 8'h00; endproperty
   a_split: assert property (p_split) else $error("request in both levels");
   property p_gmask; !global_en_i [*3] |-> (irq_high_o | irq_low_o) == 8'h00; endproperty
   a_gmask: assert property (p_gmask) else $error("request with global off");
   property p_rst; $fell(rst_i) |-> !halt_o && !idle_o && !clk_stop_o; endproperty
   a_rst: assert property (p_rst) else $error("reset left a power mode");
   c_idle: cover property (idle_o);
   c_stop: cover property (clk_stop_o);
   c_high: cover property (irq_high_o != 8'h00);
endmodule
bind xirq_power_ctrl xirq_power_ctrl_asserts u_chk (.clk_i, .rst_i, .sfr_i, .rdata_o,
   .rhit_o, .other_irq_i, .global_en_i, .irq_high_o, .irq_low_o, .halt_o,
   .clk_stop_o, .idle_o);
